/* common/tpl_pkg.sv */
// Shared constants for the two-channel position latch
package tpl_pkg;

   // Object indices as the master addresses them
   localparam logic [15:0] TPL_IDX_CTRL = 16'h60B8;
   localparam logic [15:0] TPL_IDX_STATUS = 16'h60B9;
   localparam logic [15:0] TPL_IDX_POS_ONE = 16'h60BA;
   localparam logic [15:0] TPL_IDX_POS_TWO = 16'h60BC;
   localparam logic [15:0] TPL_IDX_CFG = 16'h2650;

   // Widths and counts
   localparam int TPL_CH_NUM = 2;
   localparam int TPL_CH_BITS = 8;
   localparam int TPL_SRC_NUM = 3;
   localparam int TPL_PIN_NUM = 8;
   localparam int TPL_PIN_SEL_W = 3;
   localparam int TPL_CFG_FIELD_W = 4;
   localparam int TPL_POS_W = 32;
   localparam int TPL_DATA_W = 32;

   // Trigger source slots
   localparam int TPL_SRC_PROBE_ONE = 0;
   localparam int TPL_SRC_PROBE_TWO = 1;
   localparam int TPL_SRC_ZERO = 2;

   // Control byte fields, per channel
   localparam int TPL_CTL_EN_BIT = 0;
   localparam int TPL_CTL_MODE_BIT = 1;
   localparam int TPL_CTL_SRC_BIT = 2;
   localparam int TPL_CTL_RISE_BIT = 4;
   localparam int TPL_CTL_FALL_BIT = 5;

   // Status byte fields, per channel
   localparam int TPL_STS_EN_BIT = 0;
   localparam int TPL_STS_RISE_BIT = 1;
   localparam int TPL_STS_FALL_BIT = 2;
   localparam int TPL_STS_TOG_BIT = 7;

   // Config field: pin select in low bits, inversion above
   localparam int TPL_CFG_INV_BIT = 3;

   // Reset values
   localparam logic [15:0] TPL_CTRL_RST = 16'h0000;
   localparam logic [15:0] TPL_CFG_RST = 16'h0010;
   localparam logic [31:0] TPL_POS_RST = 32'h0000_0000;

   // Decoded object selector
   typedef enum logic [2:0] {
      TPL_OBJ_NONE,
      TPL_OBJ_CTRL,
      TPL_OBJ_STATUS,
      TPL_OBJ_POS_ONE,
      TPL_OBJ_POS_TWO,
      TPL_OBJ_CFG
   } tpl_obj_t;

endpackage : tpl_pkg

/* design/tpl_sync_edge.sv */
`timescale 1ns/100ps
// Two-stage synchroniser with polarity and edge detection
module tpl_sync_edge (
   input wire logic clk,
   input wire logic resetn,
   input wire logic raw_in,
   input wire logic invert,
   output logic level,
   output logic rise_pulse,
   output logic fall_pulse
);
   logic sync1_q; // First stage, read only by the second
   logic sync2_q; // Settled copy of the pin
   logic prev_q; // Level one cycle earlier

   // Resynchronise the pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Active level after polarity; a polarity change may fake one edge
   assign level = sync2_q ^ invert;

   // Remember the previous level for edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   // One-cycle edge pulses
   assign rise_pulse = level & ~prev_q;
   assign fall_pulse = ~level & prev_q;

endmodule : tpl_sync_edge

/* design/tpl_latch.sv */
`timescale 1ns/100ps
module tpl_latch (
   input wire logic clk,
   input wire logic resetn,
   input wire logic od_req,
   input wire logic od_write,
   input wire logic [15:0] od_index,
   input wire logic [tpl_pkg::TPL_DATA_W-1:0] od_wdata,
   output logic od_ack,
   output logic od_error,
   output logic [tpl_pkg::TPL_DATA_W-1:0] od_rdata,
   input wire logic [tpl_pkg::TPL_PIN_NUM-1:0] latch_pins,
   input wire logic encoder_zero,
   input wire logic [tpl_pkg::TPL_POS_W-1:0] feedback_position,
   input wire logic homing_active
);
   import tpl_pkg::*;

   // One clock domain: every property below samples on clk, idle in reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Object index decode, shared by the write and read paths
   function automatic tpl_obj_t tpl_decode(input logic [15:0] idx);
      tpl_obj_t obj;
      obj = TPL_OBJ_NONE;
      if (idx == TPL_IDX_CTRL) begin
         obj = TPL_OBJ_CTRL;
      end else if (idx == TPL_IDX_STATUS) begin
         obj = TPL_OBJ_STATUS;
      end else if (idx == TPL_IDX_POS_ONE) begin
         obj = TPL_OBJ_POS_ONE;
      end else if (idx == TPL_IDX_POS_TWO) begin
         obj = TPL_OBJ_POS_TWO;
      end else if (idx == TPL_IDX_CFG) begin
         obj = TPL_OBJ_CFG;
      end
      return obj;
   endfunction : tpl_decode

   tpl_obj_t obj; // Object addressed this cycle
   logic wr_ctrl; // Write to the control word
   logic wr_cfg; // Write to the input config
   logic [15:0] ctrl_q; // Shared control word
   logic [15:0] ctrl_d;
   logic [15:0] cfg_q; // Probe pin and polarity setting
   logic [15:0] status; // Shared status word
   logic [TPL_SRC_NUM-1:0] src_raw; // Selected raw pins
   logic [TPL_SRC_NUM-1:0] src_inv; // Polarity per source
   logic [TPL_SRC_NUM-1:0] src_rise; // Active-edge pulses
   logic [TPL_SRC_NUM-1:0] src_fall; // Inactive-edge pulses
   logic [TPL_CH_NUM-1:0] arm; // Enable going high this cycle
   logic [TPL_CH_NUM-1:0] hit; // Capture happens this cycle
   logic [TPL_CH_NUM-1:0] hit_rise;
   logic [TPL_CH_NUM-1:0] hit_fall;
   logic [TPL_CH_NUM-1:0] armed_q; // Channel waits for a trigger
   logic [TPL_CH_NUM-1:0] flag_rise_q; // Capture on rising edge seen
   logic [TPL_CH_NUM-1:0] flag_fall_q; // Capture on falling edge seen
   logic [TPL_CH_NUM-1:0] toggle_q; // Flips on every capture unless the channel is disabled in the same cycle
   logic [TPL_POS_W-1:0] pos_q [TPL_CH_NUM]; // Captured positions
   logic od_ack_q;
   logic od_error_q;
   logic [TPL_DATA_W-1:0] od_rdata_q;

   assign obj = tpl_decode(od_index);
   assign wr_ctrl = od_req & od_write & (obj == TPL_OBJ_CTRL);
   assign wr_cfg = od_req & od_write & (obj == TPL_OBJ_CFG);

   // Probe pins chosen by the config; zero pulse is fixed and never inverted
   assign src_raw[TPL_SRC_PROBE_ONE] =
      latch_pins[cfg_q[TPL_SRC_PROBE_ONE*TPL_CFG_FIELD_W +: TPL_PIN_SEL_W]];
   assign src_raw[TPL_SRC_PROBE_TWO] =
      latch_pins[cfg_q[TPL_SRC_PROBE_TWO*TPL_CFG_FIELD_W +: TPL_PIN_SEL_W]];
   assign src_raw[TPL_SRC_ZERO] = encoder_zero;
   assign src_inv[TPL_SRC_PROBE_ONE] =
      cfg_q[TPL_SRC_PROBE_ONE*TPL_CFG_FIELD_W + TPL_CFG_INV_BIT];
   assign src_inv[TPL_SRC_PROBE_TWO] =
      cfg_q[TPL_SRC_PROBE_TWO*TPL_CFG_FIELD_W + TPL_CFG_INV_BIT];
   assign src_inv[TPL_SRC_ZERO] = 1'b0;

   // One conditioner per trigger source; the mux sits ahead of the first flop
   for (genvar s = 0; s < TPL_SRC_NUM; s++) begin : g_src
      tpl_sync_edge u_cond (
         .clk(clk),
         .resetn(resetn),
         .raw_in(src_raw[s]),
         .invert(src_inv[s]),
         .level(),
         .rise_pulse(src_rise[s]),
         .fall_pulse(src_fall[s])
      );
   end

   // Next control word; homing forces channel one off whatever is written
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = od_wdata[15:0];
      end
      if (homing_active) begin
         ctrl_d[TPL_CTL_EN_BIT] = 1'b0;
      end
   end

   // Control word register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= TPL_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Input config register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= TPL_CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= od_wdata[15:0];
      end
   end

   // Per-channel latch logic; each channel has its own state only
   for (genvar c = 0; c < TPL_CH_NUM; c++) begin : g_ch
      localparam int B = c * TPL_CH_BITS;
      logic en_q;
      logic en_d;
      logic trig_rise;
      logic trig_fall;

      assign en_q = ctrl_q[B + TPL_CTL_EN_BIT];
      assign en_d = ctrl_d[B + TPL_CTL_EN_BIT];
      assign arm[c] = en_d & ~en_q;

      // Source selection: channel one may take the zero pulse
      if (c == 0) begin : g_src_one
         always_comb begin
            if (ctrl_q[B + TPL_CTL_SRC_BIT]) begin
               trig_rise = src_rise[TPL_SRC_ZERO];
               trig_fall = src_fall[TPL_SRC_ZERO];
            end else begin
               trig_rise = src_rise[TPL_SRC_PROBE_ONE];
               trig_fall = src_fall[TPL_SRC_PROBE_ONE];
            end
         end
      end else begin : g_src_two
         assign trig_rise = src_rise[TPL_SRC_PROBE_TWO];
         assign trig_fall = src_fall[TPL_SRC_PROBE_TWO];
      end

      // A trigger counts only when enabled, armed and its edge is selected
      assign hit_rise[c] = en_q & armed_q[c] & trig_rise & ctrl_q[B + TPL_CTL_RISE_BIT];
      assign hit_fall[c] = en_q & armed_q[c] & trig_fall & ctrl_q[B + TPL_CTL_FALL_BIT];
      assign hit[c] = (hit_rise[c] | hit_fall[c]) & ~(c == 0 && homing_active);

      // Arming: single mode disarms after the first capture
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            armed_q[c] <= 1'b0;
         end else if (!en_d) begin
            armed_q[c] <= 1'b0;
         end else if (arm[c]) begin
            armed_q[c] <= 1'b1;
         end else if (hit[c] && !ctrl_q[B + TPL_CTL_MODE_BIT]) begin
            armed_q[c] <= 1'b0;
         end
      end

      // Position capture into the channel's own register
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            pos_q[c] <= TPL_POS_RST;
         end else if (hit[c]) begin
            pos_q[c] <= feedback_position;
         end
      end

      // Capture flags; disable or re-arm clears them, so the old value is
      // never mistaken for a fresh one after the master restarts a channel
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            flag_rise_q[c] <= 1'b0;
            flag_fall_q[c] <= 1'b0;
            toggle_q[c] <= 1'b0;
         end else if (!en_d || arm[c]) begin
            flag_rise_q[c] <= 1'b0;
            flag_fall_q[c] <= 1'b0;
            toggle_q[c] <= 1'b0;
         end else if (hit[c]) begin
            flag_rise_q[c] <= flag_rise_q[c] | hit_rise[c];
            flag_fall_q[c] <= flag_fall_q[c] | hit_fall[c];
            toggle_q[c] <= ~toggle_q[c];
         end
      end

      // Status byte of this channel
      always_comb begin
         status[B +: TPL_CH_BITS] = '0;
         status[B + TPL_STS_EN_BIT] = en_q;
         status[B + TPL_STS_RISE_BIT] = flag_rise_q[c];
         status[B + TPL_STS_FALL_BIT] = flag_fall_q[c];
         status[B + TPL_STS_TOG_BIT] = toggle_q[c];
      end

      // Single mode: a capture disarms the channel
      single_hold_a: assert property (
         hit[c] && !ctrl_q[B + TPL_CTL_MODE_BIT] && !arm[c] |=> !armed_q[c])
         else $error("single mode channel still armed after capture");

      // Continuous mode: stays armed while enabled
      cont_rearm_a: assert property (
         hit[c] && ctrl_q[B + TPL_CTL_MODE_BIT] && en_d |=> armed_q[c])
         else $error("continuous mode channel lost arming");

      // Re-arm clears capture flags
      flag_clear_a: assert property (
         arm[c] |=> !flag_rise_q[c] && !flag_fall_q[c] && armed_q[c])
         else $error("capture flags not cleared on re-arm");

      // Held value: nothing overwrites the register while disarmed
      hold_value_a: assert property (
         !armed_q[c] |=> pos_q[c] == $past(pos_q[c]))
         else $error("channel register changed while not armed");
   end

   // Object access answer: one cycle after the request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         od_ack_q <= 1'b0;
         od_error_q <= 1'b0;
      end else begin
         od_ack_q <= od_req;
         // Unknown index, or a write to a read-only object
         od_error_q <= od_req & ((obj == TPL_OBJ_NONE) |
            (od_write & (obj != TPL_OBJ_CTRL) & (obj != TPL_OBJ_CFG)));
      end
   end

   // Read data; status is sampled at request time
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         od_rdata_q <= '0;
      end else if (od_req && !od_write) begin
         unique case (obj)
            TPL_OBJ_CTRL: od_rdata_q <= {16'h0000, ctrl_q};
            TPL_OBJ_STATUS: od_rdata_q <= {16'h0000, status};
            TPL_OBJ_POS_ONE: od_rdata_q <= pos_q[0];
            TPL_OBJ_POS_TWO: od_rdata_q <= pos_q[1];
            TPL_OBJ_CFG: od_rdata_q <= {16'h0000, cfg_q};
            TPL_OBJ_NONE: od_rdata_q <= '0;
         endcase
      end
   end

   assign od_ack = od_ack_q;
   assign od_error = od_error_q;
   assign od_rdata = od_rdata_q;

   // Homing switches channel one off within one cycle
   home_off_a: assert property (
      homing_active |=> !ctrl_q[TPL_CTL_EN_BIT])
      else $error("channel one still enabled during homing");

   // No channel one capture during homing
   home_block_a: assert property (
      homing_active |-> !hit[0])
      else $error("channel one captured during homing");

   // Channel one register takes the sampled position
   cap_one_value_a: assert property (
      hit[0] |=> pos_q[0] == $past(feedback_position))
      else $error("channel one register missed the position");

   // Channel two register takes the sampled position
   cap_two_value_a: assert property (
      hit[1] |=> pos_q[1] == $past(feedback_position))
      else $error("channel two register missed the position");

   // Channel two capture leaves channel one untouched
   ch_indep_a: assert property (
      hit[1] && !hit[0] |=> pos_q[0] == $past(pos_q[0]))
      else $error("channel two disturbed channel one");

   // Channel one trigger comes only from its selected source
   src_one_a: assert property (
      hit[0] |-> (ctrl_q[TPL_CTL_SRC_BIT] ?
         (src_rise[TPL_SRC_ZERO] | src_fall[TPL_SRC_ZERO]) :
         (src_rise[TPL_SRC_PROBE_ONE] | src_fall[TPL_SRC_PROBE_ONE])))
      else $error("channel one fired from wrong source");

   // Channel two follows only the second probe
   src_two_a: assert property (
      hit[1] |-> src_rise[TPL_SRC_PROBE_TWO] | src_fall[TPL_SRC_PROBE_TWO])
      else $error("channel two fired from wrong source");

   // High control byte written as given
   ctrl_high_a: assert property (
      wr_ctrl |=> ctrl_q[15:8] == $past(od_wdata[15:8]))
      else $error("channel two control byte not stored");

   // Low control byte written as given when not homing
   ctrl_low_a: assert property (
      wr_ctrl && !homing_active |=> ctrl_q[7:0] == $past(od_wdata[7:0]))
      else $error("channel one control byte not stored");

   // Low status byte reports channel one capture
   sts_low_a: assert property (
      hit_rise[0] && ctrl_d[TPL_CTL_EN_BIT] |=> status[TPL_STS_RISE_BIT])
      else $error("channel one status did not report capture");

   // High status byte reports channel two capture
   sts_high_a: assert property (
      hit_rise[1] && ctrl_d[TPL_CH_BITS + TPL_CTL_EN_BIT]
      |=> status[TPL_CH_BITS + TPL_STS_RISE_BIT])
      else $error("channel two status did not report capture");

   // Config write reaches the register
   cfg_write_a: assert property (
      wr_cfg |=> cfg_q == $past(od_wdata[15:0]))
      else $error("input config not stored");

   // Main scenarios
   single_cap_c: cover property (
      arm[0] ##[1:50] hit[0] && !ctrl_q[TPL_CTL_MODE_BIT]);
   cont_two_c: cover property (
      hit[1] && ctrl_q[TPL_CH_BITS + TPL_CTL_MODE_BIT] ##[1:50] hit[1]);
   zero_cap_c: cover property (hit[0] && ctrl_q[TPL_CTL_SRC_BIT]);
   home_off_c: cover property (ctrl_q[TPL_CTL_EN_BIT] && homing_active);
   both_cap_c: cover property (hit[0] && hit[1]);

endmodule : tpl_latch

/* test/tpl_master_model.sv */
`timescale 1ns/100ps
// Behavioural fieldbus master, one object access at a time
module tpl_master_model (
   input wire logic clk,
   output logic od_req,
   output logic od_write,
   output logic [15:0] od_index,
   output logic [tpl_pkg::TPL_DATA_W-1:0] od_wdata,
   input wire logic od_ack,
   input wire logic [tpl_pkg::TPL_DATA_W-1:0] od_rdata
);
   import tpl_pkg::*;

   logic [15:0] last_idx; // Index of the access in flight
   logic signed [TPL_POS_W-1:0] pos_one_seen; // Signed view of channel one position

   // Idle bus at time zero
   initial begin
      od_req = 1'b0;
      od_write = 1'b0;
      od_index = 16'h0000;
      od_wdata = 32'h0000_0000;
   end

   // One access: request pulse for one cycle, answer lands the edge after
   task automatic access(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge clk);
      #1;
      od_req = 1'b1;
      od_write = w;
      od_index = idx;
      od_wdata = d;
      @(posedge clk);
      #1;
      // Released lines flip so a stale value is never mistaken for a live one
      od_req = 1'b0;
      od_write = ~w;
      od_index = ~idx;
      od_wdata = ~d;
      @(posedge clk);
   endtask : access

   // Answer data is taken at the edge where the ack stands
   always @(posedge clk) begin
      if (od_req) begin
         last_idx <= od_index;
      end
      if (od_ack && last_idx == TPL_IDX_POS_ONE) begin
         pos_one_seen <= signed'(od_rdata);
      end
   end
endmodule : tpl_master_model

/* test/tb_top.sv */
`timescale 1ns/100ps
// Self-checking bench for the two-channel position latch
module tb_top;
   import tpl_pkg::*;

   // Expected answer noted by the driver
   typedef struct {
      string name;
      logic [31:0] mask;
      logic [31:0] val;
      logic err;
   } tpl_exp_t;

   logic clk;
   logic resetn;
   logic od_req;
   logic od_write;
   logic [15:0] od_index;
   logic [31:0] od_wdata;
   logic od_ack;
   logic od_error;
   logic [31:0] od_rdata;
   logic [7:0] latch_pins;
   logic encoder_zero;
   logic [31:0] feedback_position;
   logic homing_active;
   tpl_exp_t exp_q[$]; // Notes waiting for their answer
   tpl_exp_t e;
   int mismatches;
   int compares;
   logic [31:0] lfsr_q; // Random position source
   logic [31:0] p1;
   logic [31:0] p2;
   logic [31:0] q;

   tpl_latch dut (.clk(clk), .resetn(resetn), .od_req(od_req), .od_write(od_write),
      .od_index(od_index), .od_wdata(od_wdata), .od_ack(od_ack), .od_error(od_error),
      .od_rdata(od_rdata), .latch_pins(latch_pins), .encoder_zero(encoder_zero),
      .feedback_position(feedback_position), .homing_active(homing_active));

   tpl_master_model master (.clk(clk), .od_req(od_req), .od_write(od_write),
      .od_index(od_index), .od_wdata(od_wdata), .od_ack(od_ack), .od_rdata(od_rdata));

   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Galois-free shift register, taps 32 22 2 1
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Note the expectation, then let the master make the access
   task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d,
      input string name, input logic [31:0] mask, input logic [31:0] val, input logic err);
      exp_q.push_back('{name, mask, val, err});
      master.access(w, idx, d);
   endtask : acc

   task automatic rd(input logic [15:0] idx, input string name, input logic [31:0] mask,
      input logic [31:0] val);
      acc(1'b0, idx, 32'h0000_0000, name, mask, val, 1'b0);
   endtask : rd

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      acc(1'b1, idx, d, "write", 32'h0000_0000, 32'h0000_0000, 1'b0);
   endtask : wr

   // Move one trigger line (8 is the zero pulse) with a fresh position
   task automatic hit(input int b, input logic v, output logic [31:0] p);
      lfsr_q = lfsr_next(lfsr_q);
      p = lfsr_q;
      @(posedge clk);
      #1;
      feedback_position = p;
      if (b == 8) begin
         encoder_zero = v;
      end else begin
         latch_pins[b] = v;
      end
      // Two sync flops plus the store edge, with margin
      repeat (6) @(posedge clk);
   endtask : hit

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // Watcher: answers are settled at the falling edge
   always @(negedge clk) begin
      if (od_ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected ack", 32'h0000_0001, 32'h0000_0000);
         end else begin
            e = exp_q.pop_front();
            chk({e.name, " error"}, {31'h0000_0000, od_error}, {31'h0000_0000, e.err});
            chk(e.name, od_rdata & e.mask, e.val);
         end
      end
   end

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      mismatches = 0;
      compares = 0;
      resetn = 1'b0;
      latch_pins = 8'h00;
      encoder_zero = 1'b0;
      feedback_position = 32'h0000_0000;
      homing_active = 1'b0;
      lfsr_q = 32'h0000_005E;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      rd(TPL_IDX_CTRL, "ctrl", 32'hFFFF_FFFF, 32'h0000_0000);
      rd(TPL_IDX_STATUS, "status", 32'hFFFF_FFFF, 32'h0000_0000);
      rd(TPL_IDX_POS_ONE, "pos one", 32'hFFFF_FFFF, 32'h0000_0000);
      rd(TPL_IDX_POS_TWO, "pos two", 32'hFFFF_FFFF, 32'h0000_0000);
      rd(TPL_IDX_CFG, "cfg", 32'hFFFF_FFFF, 32'h0000_0010);
      acc(1'b0, 16'h1234, 32'h0000_0000, "unmapped", 32'h0000_0000, 32'h0000_0000, 1'b1);
      acc(1'b1, TPL_IDX_STATUS, 32'h0000_FFFF, "wr status", 32'h0, 32'h0, 1'b1);
      acc(1'b1, TPL_IDX_POS_ONE, 32'h1234_5678, "wr pos one", 32'h0, 32'h0, 1'b1);
      acc(1'b1, TPL_IDX_POS_TWO, 32'h1234_5678, "wr pos two", 32'h0, 32'h0, 1'b1);
      rd(TPL_IDX_POS_ONE, "pos one kept", 32'hFFFF_FFFF, 32'h0000_0000);
      // Channel one, single, rising edge of probe one
      wr(TPL_IDX_CTRL, 32'h0000_0011);
      hit(0, 1'b1, p1);
      rd(TPL_IDX_POS_ONE, "single pos", 32'hFFFF_FFFF, p1);
      rd(TPL_IDX_STATUS, "single sts", 32'h0000_0086, 32'h0000_0082);
      chk("pos one signed", master.pos_one_seen, p1);
      hit(0, 1'b0, q);
      hit(0, 1'b1, q);
      rd(TPL_IDX_POS_ONE, "single hold", 32'hFFFF_FFFF, p1);
      wr(TPL_IDX_CTRL, 32'h0000_0000);
      rd(TPL_IDX_STATUS, "disabled sts", 32'h0000_FFFF, 32'h0000_0000);
      // Channel one, continuous, both edges of the zero pulse
      wr(TPL_IDX_CTRL, 32'h0000_0037);
      hit(8, 1'b1, p1);
      rd(TPL_IDX_POS_ONE, "zero rise", 32'hFFFF_FFFF, p1);
      hit(8, 1'b0, p2);
      rd(TPL_IDX_POS_ONE, "zero fall", 32'hFFFF_FFFF, p2);
      rd(TPL_IDX_STATUS, "cont sts", 32'h0000_0086, 32'h0000_0006);
      hit(0, 1'b0, q);
      rd(TPL_IDX_POS_ONE, "probe ignored", 32'hFFFF_FFFF, p2);
      // Channel two alone, then both channels together
      wr(TPL_IDX_CTRL, 32'h0000_1100);
      hit(1, 1'b1, p1);
      rd(TPL_IDX_POS_TWO, "two pos", 32'hFFFF_FFFF, p1);
      rd(TPL_IDX_POS_ONE, "one untouched", 32'hFFFF_FFFF, p2);
      rd(TPL_IDX_STATUS, "two sts", 32'h0000_8686, 32'h0000_8200);
      wr(TPL_IDX_CTRL, 32'h0000_0000);
      wr(TPL_IDX_CTRL, 32'h0000_3311);
      hit(1, 1'b0, p1);
      hit(0, 1'b1, p2);
      rd(TPL_IDX_POS_TWO, "both two", 32'hFFFF_FFFF, p1);
      rd(TPL_IDX_POS_ONE, "both one", 32'hFFFF_FFFF, p2);
      // Probe one moved to pin 2, active low
      wr(TPL_IDX_CTRL, 32'h0000_0000);
      wr(TPL_IDX_CFG, 32'h0000_001A);
      hit(2, 1'b1, q);
      wr(TPL_IDX_CTRL, 32'h0000_0011);
      hit(0, 1'b0, q);
      hit(0, 1'b1, q);
      hit(2, 1'b0, p1);
      rd(TPL_IDX_POS_ONE, "cfg pin", 32'hFFFF_FFFF, p1);
      // Homing switches channel one off and keeps it off
      wr(TPL_IDX_CTRL, 32'h0000_0000);
      wr(TPL_IDX_CTRL, 32'h0000_0011);
      @(posedge clk);
      #1;
      homing_active = 1'b1;
      rd(TPL_IDX_CTRL, "homing ctrl", 32'h0000_0001, 32'h0000_0000);
      rd(TPL_IDX_STATUS, "homing sts", 32'h0000_0001, 32'h0000_0000);
      hit(2, 1'b1, q);
      hit(2, 1'b0, q);
      rd(TPL_IDX_POS_ONE, "homing hold", 32'hFFFF_FFFF, p1);
      wr(TPL_IDX_CTRL, 32'h0000_0011);
      rd(TPL_IDX_CTRL, "homing wr", 32'h0000_00FF, 32'h0000_0010);
      #1;
      homing_active = 1'b0;
      repeat (3) @(posedge clk);
      chk("answers left", exp_q.size(), 32'h0000_0000);
      report_and_stop();
   end
endmodule : tb_top
